// >>> dual_port_map_pkg.sv
// Constants and carrier types for the dual-port link register map.
// Assumes a single 50 MHz clock shared by both ports.
package dual_port_map_pkg;

  // ****************************************************************
  // Memory layout
  // ****************************************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned MEM_WORDS = 2624;
  localparam logic [11:0] LINK_STATUS_OFS = 12'h004;
  localparam logic [11:0] STATION_OFS = 12'h00C;
  localparam logic [11:0] KEYSWITCH_OFS = 12'h00D;
  localparam logic [11:0] RX_MSG_CNT_OFS = 12'h00E;
  localparam logic [11:0] TX_MSG_CNT_OFS = 12'h013;
  localparam logic [11:0] LINK_CFG_OFS = 12'h014;
  localparam logic [11:0] BAUD_OFS = 12'h015;
  localparam logic [11:0] RESP_TMO_OFS = 12'h016;
  localparam logic [11:0] RETRY_OFS = 12'h017;
  localparam logic [11:0] ACK_TMO_OFS = 12'h018;
  localparam logic [11:0] RX_CAPTURE_OFS = 12'h032;
  localparam logic [11:0] TX_CAPTURE_OFS = 12'h037;
  localparam logic [11:0] PART_NUM_OFS = 12'h03C;
  localparam logic [11:0] REVISION_OFS = 12'h03D;
  localparam logic [11:0] CARD_ID_HI_OFS = 12'h03E;
  localparam logic [11:0] CARD_ID_LO_OFS = 12'h03F;
  localparam logic [11:0] OUT_BIT_OFS = 12'h040;
  localparam logic [11:0] IN_BIT_OFS = 12'h140;
  localparam logic [11:0] IN_WORD_OFS = 12'h240;
  localparam logic [11:0] SHARED_WORD_OFS = 12'h640;
  localparam logic [11:0] IMAGE_END_OFS = 12'hA40;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned CONFIGURED_BIT = 0;
  localparam int unsigned UPDATE_LSB = 0;
  localparam int unsigned UPDATE_MSB = 7;
  localparam int unsigned CHECK_SEL_BIT = 13;
  localparam int unsigned CAPTURE_EN_BIT = 15;
  localparam logic [15:0] BAUD_RST = 16'h2580;
  localparam logic [15:0] RESP_TMO_RST = 16'h0003;
  localparam logic [15:0] RESP_TMO_MIN = 16'h0001;
  localparam logic [15:0] RESP_TMO_MAX = 16'h000A;
  localparam logic [15:0] RETRY_RST = 16'h0002;
  localparam logic [15:0] RETRY_MAX = 16'h0003;
  localparam logic [15:0] ACK_TMO_RST = 16'h0028;
  localparam int unsigned ACK_STEP_MS = 25;
  localparam int unsigned CLOCK_HZ = 50000000;
  localparam int unsigned ACK_STEP_CYCLES = CLOCK_HZ / 1000 * ACK_STEP_MS;
  localparam int unsigned CAPTURE_WORDS = 5;
  localparam int unsigned COUNTERS = 6;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic        req;
    logic        we;
    logic [11:0] addr;
    logic [15:0] wdata;
  } port_req_t;

  typedef struct packed {
    logic        ack;
    logic        refused;
    logic [15:0] rdata;
  } port_rsp_t;

  typedef struct packed {
    logic [15:0] baud;
    logic        check_sel;
    logic [15:0] resp_tmo;
    logic [15:0] retries;
    logic [15:0] ack_tmo;
  } link_cfg_t;

  typedef enum logic [1:0] {
    KEY_PROTECT = 2'h1,
    KEY_SETUP   = 2'h2,
    KEY_PROGRAM = 2'h3
  } key_pos_t;

endpackage : dual_port_map_pkg

// >>> dual_port_link_register_map.sv
// Shared dual-port word memory for a serial link gateway.
// Assumes both ports are synchronous to clock_i and the link engine
// outside reports events as one-cycle pulses.
// How it works
// (R1) One shared word memory reachable from backplane and serial ports.
// (R2) Below word 64, backplane may write only control words 20 through 24.
// (R3) Word 4 bit 0 set once link configuration is applied.
// (R4) Word 12 shows station number from faceplate switches.
// (R5) Word 13 shows keyswitch: 1 protect, 2 setup, 3 program.
// (R6) Words 14 to 19 count link events in documented order.
// (R7) Nonzero update flag in word 20 bits 0-7 reconfigures the link.
// (R8) Word 20 bit 13 selects check method; must match remote.
// (R9) With word 20 bit 15 set, capture ten message bytes each way.
// (R10) Word 21 selects baud rate; remote must use the same.
// (R11) Word 22 sets response timeout seconds, 1 to 10, default 3.
// (R12) Word 23 sets retry count, 0 to 3, default 2.
// (R13) Word 24 sets ACK wait in 25 ms steps, default 40.
// (R14) Bit-data section: 512 words from word 64, two 256-word files.
// (R15) Integer section: next 2048 words, two 1024-word files.
// (R16) Serial writes to input files refused; backplane to output bits.
// (R17) Serial port may read every image word.
// (R18) Words 60 to 63 hold read-only identification words.
// (R19) Station number built from tens and units decimal switches.
// (R20) Same-cycle accesses are arbitrated so no word is torn.
`timescale 1ns/100ps
module dual_port_link_register_map #(
  parameter logic [15:0] PART_NUMBER = 16'h1234, // Arbitrary value.
  parameter logic [15:0] REVISION    = 16'h3031, // Arbitrary value.
  parameter logic [31:0] CARD_ID     = 32'h5859_5A57, // Arbitrary value.
  parameter int unsigned ACK_STEP    = dual_port_map_pkg::ACK_STEP_CYCLES
) (
  input  wire logic                          clock_i,
  input  wire logic                          rst_i,
  input  wire dual_port_map_pkg::port_req_t  bp_req_i,
  output dual_port_map_pkg::port_rsp_t       bp_rsp_o,
  input  wire dual_port_map_pkg::port_req_t  ser_req_i,
  output dual_port_map_pkg::port_rsp_t       ser_rsp_o,
  input  wire logic [3:0]                    station_tens_i,
  input  wire logic [3:0]                    station_units_i,
  input  wire logic [1:0]                    keyswitch_i,
  input  wire logic [5:0]                    link_event_i,
  input  wire logic                          link_cfg_done_i,
  input  wire logic                          rx_byte_valid_i,
  input  wire logic                          rx_msg_start_i,
  input  wire logic                          tx_byte_valid_i,
  input  wire logic                          tx_msg_start_i,
  input  wire logic [7:0]                    link_byte_i,
  input  wire logic [7:0]                    tx_byte_i,
  output dual_port_map_pkg::link_cfg_t       link_cfg_o,
  output logic                               link_reconfig_o,
  output logic                               ack_step_o
);

  // ****************************************************************
  // Storage and helpers
  // ****************************************************************
  logic [15:0] image_r [dual_port_map_pkg::MEM_WORDS];
  logic [15:0] ctrl_r [5];
  logic [15:0] count_r [dual_port_map_pkg::COUNTERS];
  logic [7:0]  rx_cap_r [10];
  logic [7:0]  tx_cap_r [10];
  logic [3:0]  rx_idx_r;
  logic [3:0]  tx_idx_r;
  logic        configured_r;
  logic        pending_r;
  logic [7:0]  station_r;
  logic [21:0] step_cnt_r;
  logic        bp_ok;
  logic        ser_ok;
  logic        ser_blocked;

  function automatic logic in_range(input logic [11:0] a,
                                    input logic [11:0] lo,
                                    input logic [11:0] hi);
    in_range = (a >= lo) && (a < hi);
  endfunction : in_range

  // Maps a register-area word to its read value; image handled apart.
  function automatic logic [15:0] status_word(input logic [11:0] a);
    logic [3:0] ci;
    ci = 4'(a - dual_port_map_pkg::RX_CAPTURE_OFS);
    status_word = 16'h0000;
    case (a)
      dual_port_map_pkg::LINK_STATUS_OFS:
        status_word = {15'h0000, configured_r};
      dual_port_map_pkg::STATION_OFS:
        status_word = {8'h00, station_r};
      // (R5) Keyswitch position code.
      dual_port_map_pkg::KEYSWITCH_OFS:
        status_word = {14'h0000, keyswitch_i};
      // (R18) Fixed identification words.
      dual_port_map_pkg::PART_NUM_OFS:
        status_word = PART_NUMBER;
      dual_port_map_pkg::REVISION_OFS:
        status_word = REVISION;
      dual_port_map_pkg::CARD_ID_HI_OFS:
        status_word = CARD_ID[31:16];
      dual_port_map_pkg::CARD_ID_LO_OFS:
        status_word = CARD_ID[15:0];
      default: begin
        if (in_range(a, dual_port_map_pkg::RX_MSG_CNT_OFS,
                     dual_port_map_pkg::LINK_CFG_OFS)) begin
          status_word = count_r[3'(a - dual_port_map_pkg::RX_MSG_CNT_OFS)];
        end else if (in_range(a, dual_port_map_pkg::LINK_CFG_OFS,
                              12'h019)) begin
          status_word = ctrl_r[3'(a - dual_port_map_pkg::LINK_CFG_OFS)];
        end else if (in_range(a, dual_port_map_pkg::RX_CAPTURE_OFS,
                              dual_port_map_pkg::TX_CAPTURE_OFS)) begin
          status_word = {rx_cap_r[{ci[2:0], 1'b0}],
                         rx_cap_r[{ci[2:0], 1'b1}]};
        end else if (in_range(a, dual_port_map_pkg::TX_CAPTURE_OFS,
                              dual_port_map_pkg::PART_NUM_OFS)) begin
          ci = 4'(a - dual_port_map_pkg::TX_CAPTURE_OFS);
          status_word = {tx_cap_r[{ci[2:0], 1'b0}],
                         tx_cap_r[{ci[2:0], 1'b1}]};
        end
      end
    endcase
  endfunction : status_word

  // ****************************************************************
  // Write permission
  // ****************************************************************
  // (R2) Backplane control window.
  // (R16) Backplane barred from output bits.
  assign bp_ok = in_range(bp_req_i.addr, dual_port_map_pkg::LINK_CFG_OFS,
                          12'h019)
              || in_range(bp_req_i.addr, dual_port_map_pkg::IN_BIT_OFS,
                          dual_port_map_pkg::IMAGE_END_OFS);
  // (R16) Serial barred from input files.
  assign ser_ok = in_range(ser_req_i.addr, dual_port_map_pkg::OUT_BIT_OFS,
                           dual_port_map_pkg::IN_BIT_OFS)
               || in_range(ser_req_i.addr,
                           dual_port_map_pkg::SHARED_WORD_OFS,
                           dual_port_map_pkg::IMAGE_END_OFS);
  // (R20) Backplane wins a same-word write clash; serial write dropped.
  assign ser_blocked = bp_req_i.req && bp_req_i.we && bp_ok
                    && (bp_req_i.addr == ser_req_i.addr);

  // ****************************************************************
  // Image memory (R14, R15 layout from word 64)
  // ****************************************************************
  // (R1) Single word array shared by both ports.
  always_ff @(posedge clock_i) begin
    if (bp_req_i.req && bp_req_i.we && bp_ok
        && bp_req_i.addr >= dual_port_map_pkg::OUT_BIT_OFS) begin
      image_r[bp_req_i.addr] <= bp_req_i.wdata;
    end
    if (ser_req_i.req && ser_req_i.we && ser_ok && !ser_blocked) begin
      image_r[ser_req_i.addr] <= ser_req_i.wdata;
    end
  end

  // ****************************************************************
  // Read answers, one cycle after the request
  // ****************************************************************
  // (R17) Serial reads every word. (R20) Reads see old whole word.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bp_rsp_o  <= '0;
      ser_rsp_o <= '0;
    end else begin
      bp_rsp_o.ack     <= bp_req_i.req;
      bp_rsp_o.refused <= bp_req_i.req && bp_req_i.we && !bp_ok;
      ser_rsp_o.ack    <= ser_req_i.req;
      ser_rsp_o.refused <= ser_req_i.req && ser_req_i.we
                        && (!ser_ok || ser_blocked);
      if (bp_req_i.req && !bp_req_i.we) begin
        bp_rsp_o.rdata <= in_range(bp_req_i.addr,
                                   dual_port_map_pkg::OUT_BIT_OFS,
                                   dual_port_map_pkg::IMAGE_END_OFS)
                        ? image_r[bp_req_i.addr]
                        : status_word(bp_req_i.addr);
      end
      if (ser_req_i.req && !ser_req_i.we) begin
        ser_rsp_o.rdata <= in_range(ser_req_i.addr,
                                    dual_port_map_pkg::OUT_BIT_OFS,
                                    dual_port_map_pkg::IMAGE_END_OFS)
                         ? image_r[ser_req_i.addr]
                         : status_word(ser_req_i.addr);
      end
    end
  end

  // ****************************************************************
  // Control words 20 to 24
  // ****************************************************************
  // Out-of-range response timeout and retry values are clamped; the ACK wait is passed unclamped and may be zero.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ctrl_r[0] <= 16'h0000;
      // (R10) Baud default.
      ctrl_r[1] <= dual_port_map_pkg::BAUD_RST;
      // (R11) Response timeout default.
      ctrl_r[2] <= dual_port_map_pkg::RESP_TMO_RST;
      // (R12) Retry default.
      ctrl_r[3] <= dual_port_map_pkg::RETRY_RST;
      // (R13) ACK wait default.
      ctrl_r[4] <= dual_port_map_pkg::ACK_TMO_RST;
    end else if (bp_req_i.req && bp_req_i.we && bp_ok
                 && bp_req_i.addr < dual_port_map_pkg::OUT_BIT_OFS) begin
      ctrl_r[3'(bp_req_i.addr - dual_port_map_pkg::LINK_CFG_OFS)]
        <= bp_req_i.wdata;
    end else if (pending_r) begin
      // (R7) Update flag self-clears once applied.
      ctrl_r[0][dual_port_map_pkg::UPDATE_MSB:dual_port_map_pkg::UPDATE_LSB]
        <= 8'h00;
    end
  end

  // (R7) Reconfigure on update flag.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pending_r  <= 1'b0;
      link_cfg_o <= '0;
    end else begin
      pending_r <= |ctrl_r[0][dual_port_map_pkg::UPDATE_MSB:
                              dual_port_map_pkg::UPDATE_LSB] && !pending_r;
      if (pending_r) begin
        link_cfg_o.baud      <= ctrl_r[1];
        // (R8) Check method select.
        link_cfg_o.check_sel <= ctrl_r[0][dual_port_map_pkg::CHECK_SEL_BIT];
        // (R11) Clamp 1 to 10.
        link_cfg_o.resp_tmo  <=
          (ctrl_r[2] < dual_port_map_pkg::RESP_TMO_MIN) ?
            dual_port_map_pkg::RESP_TMO_MIN :
          (ctrl_r[2] > dual_port_map_pkg::RESP_TMO_MAX) ?
            dual_port_map_pkg::RESP_TMO_MAX : ctrl_r[2];
        // (R12) Clamp 0 to 3.
        link_cfg_o.retries   <= (ctrl_r[3] > dual_port_map_pkg::RETRY_MAX) ?
                                dual_port_map_pkg::RETRY_MAX : ctrl_r[3];
        link_cfg_o.ack_tmo   <= ctrl_r[4];
      end
    end
  end
  assign link_reconfig_o = pending_r;

  // (R3) Configured flag.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      configured_r <= 1'b0;
    end else if (link_cfg_done_i) begin
      configured_r <= 1'b1;
    end else if (pending_r) begin
      configured_r <= 1'b0;
    end
  end

  // (R13) 25 ms step tick for the ACK wait.
  always_ff @(posedge clock_i) begin
    if (rst_i || step_cnt_r == 22'(ACK_STEP - 1)) begin
      step_cnt_r <= 22'h00_0000;
    end else begin
      step_cnt_r <= step_cnt_r + 22'h00_0001;
    end
  end
  assign ack_step_o = (step_cnt_r == 22'(ACK_STEP - 1));

  // ****************************************************************
  // Station number and counters
  // ****************************************************************
  // (R4) (R19) Tens times ten plus units.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      station_r <= 8'h00;
    end else begin
      station_r <= 8'({station_tens_i, 3'b000}) + 8'({station_tens_i, 1'b0})
                 + 8'(station_units_i);
    end
  end

  // (R6) Event counters, order rx, tmo, check, overrun, framing, tx.
  always_ff @(posedge clock_i) begin
    for (int i = 0; i < dual_port_map_pkg::COUNTERS; i++) begin
      if (rst_i) begin
        count_r[i] <= 16'h0000;
      end else if (link_event_i[i]) begin
        count_r[i] <= count_r[i] + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Message capture words 50 to 59
  // ****************************************************************
  // (R9) Capture first ten bytes each way while enabled.
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_idx_r <= 4'h0;
      tx_idx_r <= 4'h0;
      for (int i = 0; i < 10; i++) begin
        rx_cap_r[i] <= 8'h00;
        tx_cap_r[i] <= 8'h00;
      end
    end else if (ctrl_r[0][dual_port_map_pkg::CAPTURE_EN_BIT]) begin
      if (rx_msg_start_i) begin
        rx_idx_r <= 4'h0;
      end else if (rx_byte_valid_i && rx_idx_r < 4'hA) begin
        rx_cap_r[rx_idx_r] <= link_byte_i;
        rx_idx_r <= rx_idx_r + 4'h1;
      end
      if (tx_msg_start_i) begin
        tx_idx_r <= 4'h0;
      end else if (tx_byte_valid_i && tx_idx_r < 4'hA) begin
        tx_cap_r[tx_idx_r] <= tx_byte_i;
        tx_idx_r <= tx_idx_r + 4'h1;
      end
    end
  end

endmodule : dual_port_link_register_map

// >>> remote_link_model.sv
// Model of the remote link engine facing the register map.
// Assumes it sees the reconfigure pulse and the applied settings.
`timescale 1ns/100ps
module remote_link_model #(
  parameter int unsigned DELAY     = 3,
  parameter logic        CHECK_SEL = 1'b1
) (
  input  wire logic                         clock_i,
  input  wire logic                         rst_i,
  input  wire logic                         reconfig_i,
  input  wire dual_port_map_pkg::link_cfg_t cfg_i,
  output logic                              cfg_done_o,
  output logic                              agree_o
);
  logic [3:0] wait_r;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wait_r <= 4'h0;
    end else if (reconfig_i) begin
      wait_r <= 4'(DELAY);
    end else if (wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end
  end
  assign cfg_done_o = (wait_r == 4'h1);
  // remote agrees on check and rate
  assign agree_o = (cfg_i.check_sel == CHECK_SEL) && (cfg_i.baud inside
    {16'h04B0, 16'h0960, 16'h12C0, 16'h2580, 16'h4B00});
endmodule : remote_link_model

// >>> dual_port_link_register_map_sva.sv
// Checker for the port behaviour of the dual-port register map.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module dual_port_link_register_map_sva (
  input wire logic                         clock_i,
  input wire logic                         rst_i,
  input wire dual_port_map_pkg::port_req_t bp_req_i,
  input wire dual_port_map_pkg::port_rsp_t bp_rsp_o,
  input wire dual_port_map_pkg::port_req_t ser_req_i,
  input wire dual_port_map_pkg::port_rsp_t ser_rsp_o,
  input wire logic [3:0]                   station_tens_i,
  input wire logic [3:0]                   station_units_i,
  input wire logic [1:0]                   keyswitch_i,
  input wire logic                         link_reconfig_o
);
  logic bw, sw, br, bp_ok, ser_ok, clash;
  assign bw = bp_req_i.req & bp_req_i.we;
  assign sw = ser_req_i.req & ser_req_i.we;
  assign br = bp_req_i.req & ~bp_req_i.we;
  assign bp_ok = bp_req_i.addr inside {[12'h014:12'h018], [12'h140:12'hA3F]};
  assign ser_ok = ser_req_i.addr inside {[12'h040:12'h13F], [12'h640:12'hA3F]};
  assign clash = bw & bp_ok & (bp_req_i.addr == ser_req_i.addr);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_bp_ack_pairs:
    assert property (1 |=> bp_rsp_o.ack == $past(bp_req_i.req))
    else $error("backplane ack unpaired");
  a_ser_ack_pairs:
    assert property (1 |=> ser_rsp_o.ack == $past(ser_req_i.req))
    else $error("serial ack unpaired");
  a_bp_write_gate:
    assert property (bw |=> bp_rsp_o.refused == !$past(bp_ok))
    else $error("backplane write gate wrong");
  a_ser_write_gate:
    assert property (sw |=> ser_rsp_o.refused == !$past(ser_ok & !clash))
    else $error("serial write gate wrong");
  a_ser_read_open:
    assert property (ser_req_i.req & !ser_req_i.we |=> !ser_rsp_o.refused)
    else $error("serial read refused");
  a_station_word:
    assert property (br && bp_req_i.addr == 12'h00C |=> bp_rsp_o.rdata ==
      {12'h000, $past(station_tens_i, 2)} * 16'h000A
      + {12'h000, $past(station_units_i, 2)})
    else $error("station word wrong");
  a_keyswitch_word:
    assert property (br && bp_req_i.addr == 12'h00D |=>
      bp_rsp_o.rdata == {14'h0000, $past(keyswitch_i)})
    else $error("keyswitch word wrong");
  a_update_reload:
    assert property (bw && bp_req_i.addr == 12'h014
      && bp_req_i.wdata[7:0] != 8'h00 |-> ##[1:3] link_reconfig_o)
    else $error("update flag ignored");
  a_reconfig_single:
    assert property (link_reconfig_o |=> !link_reconfig_o)
    else $error("reconfigure pulse too long");
endmodule : dual_port_link_register_map_sva
bind dual_port_link_register_map dual_port_link_register_map_sva chk_u (
  .clock_i(clock_i), .rst_i(rst_i), .bp_req_i(bp_req_i),
  .bp_rsp_o(bp_rsp_o), .ser_req_i(ser_req_i), .ser_rsp_o(ser_rsp_o),
  .station_tens_i(station_tens_i), .station_units_i(station_units_i),
  .keyswitch_i(keyswitch_i), .link_reconfig_o(link_reconfig_o));

// >>> tb_dual_port_link_register_map.sv
// Self-checking bench for the dual-port link register map.
// Assumes the package and design files are compiled first.
`timescale 1ns/100ps
module tb_dual_port_link_register_map;
  localparam int unsigned STEP = 4;
  localparam logic [15:0] PART = 16'hC0DE; // Arbitrary value.
  localparam logic [31:0] CARD = 32'h4142_4344; // Arbitrary value.
  logic                          clock_i, rst_i, rx_v, tx_v, rx_go, tx_go;
  logic [3:0]                    tens, units;
  logic [1:0]                    key;
  logic [5:0]                    evt;
  logic [7:0]                    rx_b, tx_b;
  logic                          done, agree, reconf, step;
  dual_port_map_pkg::port_req_t  bp_req, ser_req;
  dual_port_map_pkg::port_rsp_t  bp_rsp, ser_rsp, rb, rs;
  dual_port_map_pkg::link_cfg_t  cfg;
  int                            err_total, total_checks;
  dual_port_link_register_map #(.PART_NUMBER(PART), .REVISION(16'h3132),
    .CARD_ID(CARD), .ACK_STEP(STEP)) dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .bp_req_i(bp_req), .bp_rsp_o(bp_rsp),
    .ser_req_i(ser_req), .ser_rsp_o(ser_rsp), .station_tens_i(tens),
    .station_units_i(units), .keyswitch_i(key), .link_event_i(evt),
    .link_cfg_done_i(done), .rx_byte_valid_i(rx_v), .rx_msg_start_i(rx_go),
    .tx_byte_valid_i(tx_v), .tx_msg_start_i(tx_go), .link_byte_i(rx_b),
    .tx_byte_i(tx_b), .link_cfg_o(cfg), .link_reconfig_o(reconf),
    .ack_step_o(step));
  remote_link_model far_u (.clock_i(clock_i), .rst_i(rst_i),
    .reconfig_i(reconf), .cfg_i(cfg), .cfg_done_o(done), .agree_o(agree));
  task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  // Requests are held across exactly one sampling edge.
  task xfer(input dual_port_map_pkg::port_req_t b,
            input dual_port_map_pkg::port_req_t s);
    @(negedge clock_i);
    bp_req = b;
    ser_req = s;
    @(negedge clock_i);
    rb = bp_rsp;
    rs = ser_rsp;
    bp_req = '0;
    ser_req = '0;
  endtask : xfer
  task bp(input logic we, input logic [11:0] a, input logic [15:0] d);
    xfer({1'b1, we, a, d}, '0);
  endtask : bp
  task sp(input logic we, input logic [11:0] a, input logic [15:0] d);
    xfer('0, {1'b1, we, a, d});
  endtask : sp
  function automatic logic [15:0] fit(input logic [15:0] v, lo, hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : fit
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
  initial begin : main
    logic [15:0] dflt[5], rate[5], img[9], v, rt, ry, ak, d1, d2;
    logic [7:0]  rxa[12], txa[12];
    int          cnt[6], i, k;
    logic        bo, so;
    dflt = '{16'h0000, 16'h2580, 16'h0003, 16'h0002, 16'h0028};
    rate = '{16'h04B0, 16'h0960, 16'h12C0, 16'h2580, 16'h4B00};
    img = '{16'h0040, 16'h013F, 16'h0140, 16'h023F, 16'h0240,
            16'h063F, 16'h0640, 16'h0A3F, 16'h0A40};
    err_total = 0;
    total_checks = 0;
    {rx_v, tx_v, rx_go, tx_go, evt, rx_b, tx_b} = '0;
    rst_i = 1'b1;
    {bp_req, ser_req, tens, units} = '0;
    key = 2'h1;
    v = 16'($urandom(53));
    repeat (12) @(negedge clock_i);
    rst_i = 1'b0;
    for (i = 0; i < 5; i++) begin
      bp(1'b0, 12'h014 + 12'(i), 16'h0000);
      chk("cfg default", rb.rdata, dflt[i]);
    end
    for (i = 0; i < 64; i++) begin
      bp(1'b1, 12'(i), (i == 20) ? 16'h0000 : 16'($urandom));
      chk("bp ctl write", 16'(rb.refused), 16'(!(i inside {[20:24]})));
    end
    v = rate[$urandom % 5];
    rt = 16'($urandom % 16);
    ry = 16'($urandom % 6);
    ak = 16'($urandom);
    bp(1'b1, 12'h015, v);
    bp(1'b1, 12'h016, rt);
    bp(1'b1, 12'h017, ry);
    bp(1'b1, 12'h018, ak);
    bp(1'b1, 12'h014, 16'hA000 | 16'(1 + $urandom % 255));
    for (k = 0; k < 30 && !done; k++) @(negedge clock_i);
    @(negedge clock_i);
    chk("baud", cfg.baud, v);
    chk("check sel", 16'(cfg.check_sel), 16'h0001);
    chk("resp tmo", cfg.resp_tmo, fit(rt, 16'h0001, 16'h000A));
    chk("retries", cfg.retries, fit(ry, 16'h0000, 16'h0003));
    chk("ack tmo", cfg.ack_tmo, ak);
    chk("far agrees", 16'(agree), 16'h0001);
    bp(1'b0, 12'h004, 16'h0000);
    chk("configured", rb.rdata & 16'h0001, 16'h0001);
    bp(1'b0, 12'h014, 16'h0000);
    chk("update flag", rb.rdata, 16'hA000);
    for (i = 1; i < 4; i++) begin
      key = 2'(i);
      tens = 4'($urandom % 10);
      units = 4'($urandom % 10);
      bp(1'b0, 12'h00C, 16'h0000);
      chk("station", rb.rdata, 16'(tens) * 16'h000A + 16'(units));
      bp(1'b0, 12'h00D, 16'h0000);
      chk("keyswitch", rb.rdata, 16'(i));
    end
    cnt = '{default: 0};
    for (i = 0; i < 20; i++) begin
      @(negedge clock_i);
      evt = 6'($urandom);
      for (k = 0; k < 6; k++) cnt[k] += int'(evt[k]);
    end
    @(negedge clock_i);
    evt = 6'h00;
    for (k = 0; k < 6; k++) begin
      bp(1'b0, 12'h00E + 12'(k), 16'h0000);
      chk("counter", rb.rdata, 16'(cnt[k]));
    end
    for (i = 0; i < 12; i++) {rxa[i], txa[i]} = 16'($urandom);
    @(negedge clock_i);
    {rx_go, tx_go} = 2'h3;
    for (i = 0; i < 12; i++) begin
      @(negedge clock_i);
      {rx_go, tx_go, rx_v, tx_v, rx_b, tx_b} = {4'h3, rxa[i], txa[i]};
    end
    @(negedge clock_i);
    {rx_v, tx_v} = 2'h0;
    for (k = 0; k < 5; k++) begin
      bp(1'b0, 12'h032 + 12'(k), 16'h0000);
      chk("rx capture", rb.rdata, {rxa[2 * k], rxa[2 * k + 1]});
      bp(1'b0, 12'h037 + 12'(k), 16'h0000);
      chk("tx capture", rb.rdata, {txa[2 * k], txa[2 * k + 1]});
    end
    bp(1'b0, 12'h03C, 16'h0000);
    chk("part", rb.rdata, PART);
    bp(1'b0, 12'h03D, 16'h0000);
    chk("revision", rb.rdata, 16'h3132);
    bp(1'b0, 12'h03E, 16'h0000);
    chk("ident hi", rb.rdata, CARD[31:16]);
    bp(1'b0, 12'h03F, 16'h0000);
    chk("ident lo", rb.rdata, CARD[15:0]);
    for (i = 0; i < 9; i++) begin
      bo = img[i] inside {[16'h0140:16'h0A3F]};
      so = img[i] inside {[16'h0040:16'h013F], [16'h0640:16'h0A3F]};
      d1 = 16'($urandom);
      d2 = 16'($urandom);
      bp(1'b1, img[i][11:0], d1);
      chk("bp image wr", 16'(rb.refused), 16'(!bo));
      sp(1'b1, img[i][11:0], d2);
      chk("ser image wr", 16'(rs.refused), 16'(!so));
      sp(1'b0, img[i][11:0], 16'h0000);
      if (bo || so) chk("ser image rd", rs.rdata, so ? d2 : d1);
      bp(1'b0, img[i][11:0], 16'h0000);
      if (bo || so) chk("bp image rd", rb.rdata, so ? d2 : d1);
    end
    xfer({2'h3, 12'h700, d1}, {2'h3, 12'h700, d2});
    chk("clash loser", 16'(rs.refused), 16'h0001);
    xfer({2'h3, 12'h700, d2}, {2'h2, 12'h700, 16'h0000});
    chk("old word", rs.rdata, d1);
    sp(1'b0, 12'h700, 16'h0000);
    chk("new word", rs.rdata, d2);
    for (k = 0; k < 10 && !step; k++) @(negedge clock_i);
    k = 0;
    do begin
      @(negedge clock_i);
      k++;
    end while (!step && k < 10);
    chk("step gap", 16'(k), 16'(STEP));
    wrap_up();
  end
endmodule : tb_dual_port_link_register_map
